// *** verilog/bst_regs.svh ***
/*
 * constants of the boundary-scan port: lengths, instruction codes,
 * identity fields, controller register map and link timing.
 * assumes inclusion by name from the package, the checker and the testbench.
 */
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// ---------------------------------------------------------------
// lengths and codes
// ---------------------------------------------------------------
`define BST_IR_LEN     10
`define BST_BSR_LEN    480
`define BST_USR_LEN    7
`define BST_IR_CAPT    10'h001
`define BST_I_EXTEST   10'h000
`define BST_I_SAMPLE   10'h055
`define BST_I_IDENT    10'h059
`define BST_I_USER     10'h079
`define BST_I_CFGLD    10'h002
`define BST_I_CFGEND   10'h003
`define BST_I_BYPASS   10'h3ff
// identity values below are arbitrary
`define BST_ID_VER     4'h3
`define BST_ID_PART    16'h5a5a
`define BST_ID_MFR     11'h2a5
`define BST_USR_FIXED  25'h15a5a5a

// ---------------------------------------------------------------
// controller registers
// ---------------------------------------------------------------
`define BST_A_CTRL     8'h00
`define BST_A_LEN      8'h04
`define BST_A_TXD      8'h08
`define BST_A_RXD      8'h0c
`define BST_A_STAT     8'h10
`define BST_C_GO       0
`define BST_C_IR       1
`define BST_C_RST      2
`define BST_RST_LAST   11'd5
`define BST_HDR_DR     11'd2
`define BST_HDR_IR     11'd3

// ---------------------------------------------------------------
// link timing
// ---------------------------------------------------------------
`define BST_CLK_NS     25
`define BST_TCK_NS     100
`define BST_TCK_HALF   ((`BST_TCK_NS+2*`BST_CLK_NS-1)/(2*`BST_CLK_NS))

`endif

// *** verilog/bst_pkg.sv ***
/*
 * types shared by both ends: sequencer states, data-register
 * selection and the state records.
 * assumes bst_regs.svh is on the include path.
 */
`include "bst_regs.svh"
package bst_pkg;

    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR,
        TS_PAU_DR, TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR,
        TS_SH_IR, TS_EX1_IR, TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
    } bst_tap_t;

    typedef enum logic [2:0] {
        DS_BYP, DS_BSR, DS_ID, DS_USR, DS_CFG
    } bst_dsel_t;

    typedef enum logic [1:0] {
        SG_RST, SG_HDR, SG_SHIFT, SG_TAIL
    } bst_seg_t;

    typedef struct packed {
        bst_tap_t                 st;
        logic [`BST_IR_LEN-1:0]   ir_sh;
        logic [`BST_IR_LEN-1:0]   ir;
        logic                     byp;
        logic [31:0]              dr32;
        logic [`BST_BSR_LEN-1:0]  bsr_sh;
        logic [`BST_BSR_LEN-1:0]  bsr_up;
        logic [`BST_BSR_LEN-1:0]  pin_s1;
        logic [`BST_BSR_LEN-1:0]  pin_s2;
        logic [7:0]               cfg_sh;
        logic [2:0]               cfg_cnt;
        logic [7:0]               cfg_byte;
        logic                     cfg_vld;
        logic                     cfg_busy;
    } bst_dev_t;

    typedef struct packed {
        logic        busy;
        bst_seg_t    seg;
        logic [10:0] cnt;
        logic [2:0]  div;
        logic        tck;
        logic        tms;
        logic        tdi;
        logic        oe;
        logic        ir_op;
        logic        rst_op;
        logic [10:0] len;
        logic [31:0] txd;
        logic [31:0] rxd;
        logic [31:0] rdata;
        logic        tdo_s1;
        logic        tdo_s2;
    } bst_host_t;

endpackage : bst_pkg

// *** verilog/bst_if.sv ***
/*
 * the four-wire test port between tester and device.
 * assumes the host drives the clock; pull-ups resolve idle wires.
 */
`timescale 1ns/1ps
interface bst_if;
    logic tck;
    logic tms_o;
    logic tms_oe;
    logic tdi_o;
    logic tdi_oe;
    logic tdo_o;
    logic tdo_oe;
    logic tms;
    logic tdi;
    logic tdo;

    // weak pull-ups: an undriven wire reads high
    assign tms = tms_oe ? tms_o : 1'b1;
    assign tdi = tdi_oe ? tdi_o : 1'b1;
    assign tdo = tdo_oe ? tdo_o : 1'b1;

    modport dev (input tck, input tms, input tdi,
                 output tdo_o, output tdo_oe);
    modport host (output tck, output tms_o, output tms_oe,
                  output tdi_o, output tdi_oe, input tdo);
endinterface : bst_if

// *** verilog/bst_tap_dev.sv ***
/*
 * device end: test access port sequencer, instruction register and
 * data registers, boundary cells and configuration byte stream.
 * assumes tck comes from the tester; rstn is power-on reset.
 */
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module bst_tap_dev
    import bst_pkg::*;
(
    bst_if.dev                      jt,       // test port
    input  wire logic               rstn,     // power-on reset
    input  wire logic [`BST_BSR_LEN-1:0] pin_in,   // pin levels
    input  wire logic [`BST_BSR_LEN-1:0] core_out, // core drive
    output logic [`BST_BSR_LEN-1:0] pin_out,  // to pads
    input  wire logic [`BST_USR_LEN-1:0] usr_bits, // user sig
    output logic [7:0]              cfg_byte, // config byte
    output logic                    cfg_vld,  // byte pulse
    output logic                    cfg_busy  // config running
);

    // ---------------------------------------------------------------
    // decoding
    // ---------------------------------------------------------------
    function automatic bst_tap_t tap_next(bst_tap_t st, logic tms);
        case (st)
            TS_RESET:  tap_next = tms ? TS_RESET  : TS_IDLE;
            TS_IDLE:   tap_next = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: tap_next = tms ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: tap_next = tms ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR:  tap_next = tms ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: tap_next = tms ? TS_UPD_DR : TS_PAU_DR;
            TS_PAU_DR: tap_next = tms ? TS_EX2_DR : TS_PAU_DR;
            TS_EX2_DR: tap_next = tms ? TS_UPD_DR : TS_SH_DR;
            TS_UPD_DR: tap_next = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: tap_next = tms ? TS_RESET  : TS_CAP_IR;
            TS_CAP_IR: tap_next = tms ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR:  tap_next = tms ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: tap_next = tms ? TS_UPD_IR : TS_PAU_IR;
            TS_PAU_IR: tap_next = tms ? TS_EX2_IR : TS_PAU_IR;
            TS_EX2_IR: tap_next = tms ? TS_UPD_IR : TS_SH_IR;
            TS_UPD_IR: tap_next = tms ? TS_SEL_DR : TS_IDLE;
            default:   tap_next = TS_RESET;
        endcase
    endfunction : tap_next

    function automatic bst_dsel_t dr_decode(
        logic [`BST_IR_LEN-1:0] ir, logic busy);
        case (ir)
            `BST_I_SAMPLE: dr_decode = busy ? DS_BYP : DS_BSR;
            `BST_I_EXTEST: dr_decode = busy ? DS_BYP : DS_BSR;
            `BST_I_IDENT:  dr_decode = DS_ID;
            `BST_I_USER:   dr_decode = DS_USR;
            `BST_I_CFGLD:  dr_decode = DS_CFG;
            default:       dr_decode = DS_BYP;
        endcase
    endfunction : dr_decode

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    bst_dev_t  s_r;
    bst_dev_t  s_nxt;
    bst_dsel_t sel;
    logic      extest;
    logic      tdo_bit;
    logic      tdo_r;
    logic      tdo_oe_r;

    assign sel    = dr_decode(s_r.ir, s_r.cfg_busy);
    assign extest = (s_r.ir == `BST_I_EXTEST) && !s_r.cfg_busy;

    always_comb begin
        s_nxt        = s_r;
        s_nxt.cfg_vld = 1'b0;
        s_nxt.pin_s1 = pin_in;
        s_nxt.pin_s2 = s_r.pin_s1;
        s_nxt.st     = tap_next(s_r.st, jt.tms);
        case (s_r.st)
            TS_RESET: begin
                s_nxt.ir = `BST_I_IDENT;
            end
            TS_CAP_IR: begin
                s_nxt.ir_sh = `BST_IR_CAPT;
            end
            TS_SH_IR: begin
                s_nxt.ir_sh = {jt.tdi, s_r.ir_sh[`BST_IR_LEN-1:1]};
            end
            TS_UPD_IR: begin
                s_nxt.ir = s_r.ir_sh;
                if (s_r.ir_sh == `BST_I_CFGEND) begin
                    s_nxt.cfg_busy = 1'b0;
                end
            end
            TS_CAP_DR: begin
                case (sel)
                    DS_BYP: s_nxt.byp = 1'b0;
                    DS_ID: begin
                        s_nxt.dr32 = {`BST_ID_VER, `BST_ID_PART,
                                      `BST_ID_MFR, 1'b1};
                    end
                    DS_USR: begin
                        s_nxt.dr32 = {`BST_USR_FIXED, usr_bits};
                    end
                    DS_BSR: s_nxt.bsr_sh = s_r.pin_s2;
                    DS_CFG: s_nxt.cfg_cnt = 3'h0;
                    default: ;
                endcase
            end
            TS_SH_DR: begin
                case (sel)
                    DS_BYP: s_nxt.byp = jt.tdi;
                    DS_ID, DS_USR: begin
                        s_nxt.dr32 = {jt.tdi, s_r.dr32[31:1]};
                    end
                    DS_BSR: begin
                        s_nxt.bsr_sh = {jt.tdi,
                            s_r.bsr_sh[`BST_BSR_LEN-1:1]};
                    end
                    DS_CFG: begin
                        s_nxt.cfg_sh   = {jt.tdi, s_r.cfg_sh[7:1]};
                        s_nxt.cfg_cnt  = s_r.cfg_cnt + 3'h1;
                        s_nxt.cfg_busy = 1'b1;
                        if (s_r.cfg_cnt == 3'h7) begin
                            s_nxt.cfg_byte = {jt.tdi, s_r.cfg_sh[7:1]};
                            s_nxt.cfg_vld  = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            TS_UPD_DR: begin
                if (sel == DS_BSR) begin
                    s_nxt.bsr_up = s_r.bsr_sh;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge jt.tck or negedge rstn) begin
        if (!rstn) begin
            s_r    <= '0;
            s_r.st <= TS_RESET;
            s_r.ir <= `BST_I_IDENT;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // serial output
    // ---------------------------------------------------------------
    always_comb begin
        tdo_bit = 1'b0;
        if (s_r.st == TS_SH_IR) begin
            tdo_bit = s_r.ir_sh[0];
        end else if (s_r.st == TS_SH_DR) begin
            case (sel)
                DS_BYP:        tdo_bit = s_r.byp;
                DS_ID, DS_USR: tdo_bit = s_r.dr32[0];
                DS_BSR:        tdo_bit = s_r.bsr_sh[0];
                DS_CFG:        tdo_bit = s_r.cfg_sh[0];
                default:       tdo_bit = 1'b0;
            endcase
        end
    end

    // output changes on the falling edge, half a period before sampling
    always_ff @(negedge jt.tck or negedge rstn) begin
        if (!rstn) begin
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            tdo_r    <= tdo_bit;
            tdo_oe_r <= (s_r.st == TS_SH_IR) || (s_r.st == TS_SH_DR);
        end
    end

    assign jt.tdo_o  = tdo_r;
    assign jt.tdo_oe = tdo_oe_r;

    // ---------------------------------------------------------------
    // boundary cells toward the pads
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `BST_BSR_LEN; gi = gi + 1) begin : g_cell
            // only external test overrides the core
            assign pin_out[gi] = extest ? s_r.bsr_up[gi]
                                        : core_out[gi];
        end
    endgenerate

    assign cfg_byte = s_r.cfg_byte;
    assign cfg_vld  = s_r.cfg_vld;
    assign cfg_busy = s_r.cfg_busy;

endmodule : bst_tap_dev

// *** verilog/bst_tap_host.sv ***
/*
 * tester end: register-driven scan sequencer that makes the test
 * clock from clk and shifts instruction or data scans.
 * assumes a plain register port on clk; tdo arrives asynchronously.
 */
`timescale 1ns/1ps
module bst_tap_host
    import bst_pkg::*;
(
    input  wire logic        clk,   // 40 MHz
    input  wire logic        rstn,  // async reset
    input  wire logic [7:0]  addr,  // register address
    input  wire logic [31:0] wdata, // write data
    input  wire logic        wr,    // write strobe
    input  wire logic        rd,    // read strobe
    output logic [31:0]      rdata, // read data, next cycle
    bst_if.host              jt     // test port
);

    // ---------------------------------------------------------------
    // step sequencing
    // ---------------------------------------------------------------
    function automatic logic [10:0] seg_last(bst_seg_t g, logic ir,
                                             logic [10:0] len);
        case (g)
            SG_RST:   seg_last = `BST_RST_LAST;
            SG_HDR:   seg_last = ir ? `BST_HDR_IR : `BST_HDR_DR;
            SG_SHIFT: seg_last = len - 11'd1;
            SG_TAIL:  seg_last = 11'd1;
            default:  seg_last = 11'd0;
        endcase
    endfunction : seg_last

    function automatic logic step_tms(bst_seg_t g, logic [10:0] c,
                                      logic ir, logic [10:0] len);
        case (g)
            SG_RST:   step_tms = (c < `BST_RST_LAST);
            SG_HDR:   step_tms = ir ? (c < 11'd2) : (c < 11'd1);
            SG_SHIFT: step_tms = (c == len - 11'd1);
            SG_TAIL:  step_tms = (c == 11'd0);
            default:  step_tms = 1'b1;
        endcase
    endfunction : step_tms

    bst_host_t   s_r;
    bst_host_t   s_nxt;
    logic        fire;
    logic [10:0] len_eff;
    logic [31:0] rd_val;

    // instruction scans are always exactly the register length
    assign len_eff = s_r.ir_op ? 11'(`BST_IR_LEN)
                   : ((s_r.len == 11'd0) ? 11'd1 : s_r.len);
    assign fire = s_r.busy && (s_r.div == 3'(`BST_TCK_HALF - 1));

    always_comb begin
        case (addr)
            `BST_A_CTRL: rd_val = {29'h0, s_r.rst_op, s_r.ir_op, s_r.busy};
            `BST_A_LEN:  rd_val = {21'h0, s_r.len};
            `BST_A_TXD:  rd_val = s_r.txd;
            `BST_A_RXD:  rd_val = s_r.rxd;
            `BST_A_STAT: rd_val = {31'h0, s_r.busy};
            default:     rd_val = 32'h0;
        endcase
    end

    always_comb begin
        s_nxt        = s_r;
        s_nxt.oe     = 1'b1;
        s_nxt.tdo_s1 = jt.tdo;
        s_nxt.tdo_s2 = s_r.tdo_s1;
        s_nxt.rdata  = rd ? rd_val : 32'h0;
        s_nxt.div    = (s_r.busy && !fire) ? s_r.div + 3'h1 : 3'h0;
        if (fire && !s_r.tck) begin
            s_nxt.tck = 1'b1;
        end else if (fire) begin
            s_nxt.tck = 1'b0;
            if (s_r.seg == SG_SHIFT) begin
                s_nxt.rxd = {s_r.tdo_s2, s_r.rxd[31:1]};
            end
            if (s_r.cnt != seg_last(s_r.seg, s_r.ir_op, len_eff)) begin
                s_nxt.cnt = s_r.cnt + 11'd1;
            end else if (s_r.seg == SG_HDR) begin
                s_nxt.seg = SG_SHIFT;
                s_nxt.cnt = 11'd0;
            end else if (s_r.seg == SG_SHIFT) begin
                s_nxt.seg = SG_TAIL;
                s_nxt.cnt = 11'd0;
            end else begin
                s_nxt.busy = 1'b0;
            end
            s_nxt.tms = step_tms(s_nxt.seg, s_nxt.cnt, s_r.ir_op,
                                 len_eff);
            s_nxt.tdi = (s_nxt.seg == SG_SHIFT)
                      ? s_r.txd[s_nxt.cnt[4:0]] : 1'b1;
        end
        if (wr && !s_r.busy) begin
            case (addr)
                `BST_A_LEN: s_nxt.len = wdata[10:0];
                `BST_A_TXD: s_nxt.txd = wdata;
                `BST_A_CTRL: begin
                    s_nxt.ir_op  = wdata[`BST_C_IR];
                    s_nxt.rst_op = wdata[`BST_C_RST];
                    if (wdata[`BST_C_GO]) begin
                        s_nxt.busy = 1'b1;
                        s_nxt.seg  = wdata[`BST_C_RST] ? SG_RST : SG_HDR;
                        s_nxt.cnt  = 11'd0;
                        s_nxt.div  = 3'h0;
                        s_nxt.tck  = 1'b0;
                        s_nxt.tms  = 1'b1;
                        s_nxt.tdi  = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r     <= '0;
            s_r.tms <= 1'b1;
            s_r.tdi <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata     = s_r.rdata;
    assign jt.tck    = s_r.tck;
    assign jt.tms_o  = s_r.tms;
    assign jt.tms_oe = s_r.oe;
    assign jt.tdi_o  = s_r.tdi;
    assign jt.tdi_oe = s_r.oe;

endmodule : bst_tap_host

// *** verification/bst_tap_props.sv ***
/*
 * checker of the test port wires: tap sequence, shifted words, enables
 * and test clock shape.
 * assumes instantiation beside the interface, both clocks supplied.
 */
`timescale 1ns/1ps
`include "bst_regs.svh"
module bst_tap_props
    import bst_pkg::*;
(
    input wire logic clk,    // host clock
    input wire logic rstn,   // async reset
    input wire logic tck,    // test clock
    input wire logic tms_o,  // host mode drive
    input wire logic tms_oe, // host mode enable
    input wire logic tdi_o,  // host data drive
    input wire logic tdi_oe, // host data enable
    input wire logic tms,    // resolved mode
    input wire logic tdi,    // resolved data in
    input wire logic tdo,    // resolved data out
    input wire logic tdo_oe  // device out enable
);
    localparam logic [9:0]  IR_CAP = `BST_IR_CAPT;
    localparam logic [31:0] ID_W   = {`BST_ID_VER, `BST_ID_PART,
                                      `BST_ID_MFR, 1'b1};
    localparam logic [31:0] USR_W  = {`BST_USR_FIXED, 7'h0};
    bst_tap_t    st_r;
    bst_tap_t    st_nxt;
    logic [9:0]  irs_r;
    logic [9:0]  ir_r;
    logic [10:0] cnt_r;
    logic        sh;

    // ---------------------------------------------------------------
    // reference sequencer
    // ---------------------------------------------------------------
    assign sh = (st_r == TS_SH_DR) || (st_r == TS_SH_IR);
    always_comb begin
        case (st_r)
            TS_RESET:  st_nxt = tms ? TS_RESET : TS_IDLE;
            TS_IDLE:   st_nxt = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: st_nxt = tms ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: st_nxt = tms ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR:  st_nxt = tms ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: st_nxt = tms ? TS_UPD_DR : TS_PAU_DR;
            TS_PAU_DR: st_nxt = tms ? TS_EX2_DR : TS_PAU_DR;
            TS_EX2_DR: st_nxt = tms ? TS_UPD_DR : TS_SH_DR;
            TS_SEL_IR: st_nxt = tms ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR: st_nxt = tms ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR:  st_nxt = tms ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: st_nxt = tms ? TS_UPD_IR : TS_PAU_IR;
            TS_PAU_IR: st_nxt = tms ? TS_EX2_IR : TS_PAU_IR;
            TS_EX2_IR: st_nxt = tms ? TS_UPD_IR : TS_SH_IR;
            default:   st_nxt = tms ? TS_SEL_DR : TS_IDLE;
        endcase
    end
    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            st_r  <= TS_RESET;
            irs_r <= 10'h000;
            ir_r  <= `BST_I_IDENT;
            cnt_r <= 11'h000;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= sh ? cnt_r + 11'h001 : 11'h000;
            if (st_r == TS_CAP_IR)
                irs_r <= IR_CAP;
            else if (st_r == TS_SH_IR)
                irs_r <= {tdi, irs_r[9:1]};
            if (st_r == TS_RESET)
                ir_r <= `BST_I_IDENT;
            else if (st_r == TS_UPD_IR)
                ir_r <= irs_r;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_oe_shift: assert property (@(posedge tck) disable iff (!rstn)
        tdo_oe == sh) else $error("tdo enable outside shift");
    a_idle_high: assert property (@(posedge clk)
        !rstn |-> !tdo_oe && !tms_oe && !tdi_oe && tdo && tms && tdi)
        else $error("port not released in reset");
    a_ir_capture: assert property (@(posedge tck) disable iff (!rstn)
        st_r == TS_SH_IR && cnt_r < 10 |-> tdo == IR_CAP[cnt_r[3:0]])
        else $error("instruction capture bits wrong");
    a_ident_bits: assert property (@(posedge tck) disable iff (!rstn)
        st_r == TS_SH_DR && ir_r == `BST_I_IDENT && cnt_r < 32
        |-> tdo == ID_W[cnt_r[4:0]]) else $error("identity bit wrong");
    a_user_fixed: assert property (@(posedge tck) disable iff (!rstn)
        st_r == TS_SH_DR && ir_r == `BST_I_USER && cnt_r >= 7 &&
        cnt_r < 32 |-> tdo == USR_W[cnt_r[4:0]])
        else $error("signature fixed bit wrong");
    a_bypass_delay: assert property (@(posedge tck) disable iff (!rstn)
        st_r == TS_SH_DR && ir_r == `BST_I_BYPASS && cnt_r > 0
        |-> tdo == $past(tdi)) else $error("bypass delay wrong");
    a_tck_high: assert property (@(posedge clk) disable iff (!rstn)
        $rose(tck) |-> ##1 tck ##1 !tck) else $error("tck high time");
    a_tck_low: assert property (@(posedge clk) disable iff (!rstn)
        $fell(tck) |-> ##1 !tck) else $error("tck low time");
    a_tms_hold: assert property (@(posedge clk) disable iff (!rstn)
        tck |-> $stable(tms_o) && $stable(tdi_o))
        else $error("host drive moved while tck high");
    a_host_drive: assert property (@(posedge clk) disable iff (!rstn)
        $past(rstn) |-> tms_oe && tdi_oe) else $error("host not driving");

    c_bypass: cover property (@(posedge tck) disable iff (!rstn)
        st_r == TS_UPD_IR && irs_r == `BST_I_BYPASS);
    c_long: cover property (@(posedge tck) disable iff (!rstn)
        st_r == TS_SH_DR && cnt_r == 11'd479);
    c_reset: cover property (@(posedge tck) disable iff (!rstn) tms[*5]);
endmodule : bst_tap_props

// *** verification/bst_tap_bench.sv ***
/*
 * testbench joining tester end and device end over the test port.
 * assumes the design files and the checker are compiled before it.
 */
`timescale 1ns/1ps
`include "bst_regs.svh"
module bst_tap_bench;
    logic [7:0]   addr;
    logic [31:0]  wdata;
    logic [31:0]  rdata;
    logic [479:0] pin_in;
    logic [479:0] core_out;
    logic [479:0] pin_out;
    logic [6:0]   usr_bits;
    logic [7:0]   cfg_byte;
    logic         clk, rstn, wr, rd, cfg_vld, cfg_busy;
    int           n_errors, checks_done, n_vld;

    bst_if jt();
    bst_tap_dev i_bst_tap_dev(.jt(jt), .rstn(rstn), .pin_in(pin_in),
        .core_out(core_out), .pin_out(pin_out), .usr_bits(usr_bits),
        .cfg_byte(cfg_byte), .cfg_vld(cfg_vld), .cfg_busy(cfg_busy));
    bst_tap_host i_bst_tap_host(.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .jt(jt));
    bst_tap_props i_bst_tap_props(.clk(clk), .rstn(rstn), .tck(jt.tck),
        .tms_o(jt.tms_o), .tms_oe(jt.tms_oe), .tdi_o(jt.tdi_o),
        .tdi_oe(jt.tdi_oe), .tms(jt.tms), .tdi(jt.tdi), .tdo(jt.tdo),
        .tdo_oe(jt.tdo_oe));

    always #12.5 clk = ~clk;
    always @(negedge jt.tck) if (cfg_vld === 1'b1) n_vld++;

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask : rd_reg
    // ctrl 1: data scan, 3: instruction scan, 5: reset sequence
    task automatic run(input logic [31:0] ctrl, input logic [10:0] n,
                       input logic [31:0] t, output logic [31:0] r);
        logic [31:0] s;
        int k;
        wr_reg(`BST_A_LEN, {21'h0, n});
        wr_reg(`BST_A_TXD, t);
        wr_reg(`BST_A_CTRL, ctrl);
        s = 32'h1;
        for (k = 0; k < 2000 && s[0] !== 1'b0; k++)
            rd_reg(`BST_A_STAT, s);
        check("busy", s, 32'h0);
        rd_reg(`BST_A_RXD, r);
    endtask : run

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] r;
        wr_reg(8'h20, 32'hffff_ffff);
        rd_reg(8'h20, r);
        check("unmapped", r, 32'h0);
        wr_reg(`BST_A_TXD, 32'h1234_5678);
        rd_reg(`BST_A_TXD, r);
        check("txd back", r, 32'h1234_5678);
    endtask : t_regs
    task automatic t_ident;
        logic [31:0] r;
        run(32'h5, 11'd0, 32'h0, r);
        run(32'h1, 11'd32, 32'h0, r);
        check("ident", r, {`BST_ID_VER, `BST_ID_PART,
                           `BST_ID_MFR, 1'b1});
        check("ident lsb", {31'h0, r[0]}, 32'h1);
    endtask : t_ident
    task automatic t_user;
        logic [31:0] r;
        run(32'h3, 11'd0, {22'h0, `BST_I_USER}, r);
        check("ir capture", {22'h0, r[31:22]}, {22'h0, `BST_IR_CAPT});
        run(32'h1, 11'd32, 32'h0, r);
        check("user", r, {`BST_USR_FIXED, 7'h5b});
    endtask : t_user
    task automatic t_bypass;
        logic [31:0] r;
        run(32'h3, 11'd0, {22'h0, `BST_I_BYPASS}, r);
        run(32'h1, 11'd3, 32'h5, r);
        check("bypass", {29'h0, r[31:29]}, 32'h2);
    endtask : t_bypass
    task automatic t_pins;
        logic [31:0]  r;
        logic [31:0]  t;
        logic [479:0] e;
        t = 32'h3c5a_96e1;
        for (int i = 0; i < 480; i++) e[i] = t[i % 32];
        run(32'h3, 11'd0, {22'h0, `BST_I_SAMPLE}, r);
        run(32'h1, 11'd480, t, r);
        check("sample", r, pin_in[479:448]);
        check("pins kept", {31'h0, pin_out === core_out}, 32'h1);
        run(32'h3, 11'd0, {22'h0, `BST_I_EXTEST}, r);
        check("preload driven", {31'h0, pin_out === e}, 32'h1);
        run(32'h1, 11'd480, ~t, r);
        check("extest capture", r, pin_in[479:448]);
        check("pins updated", {31'h0, pin_out === ~e}, 32'h1);
    endtask : t_pins
    task automatic t_cfg;
        logic [31:0] r;
        run(32'h3, 11'd0, {22'h0, `BST_I_CFGLD}, r);
        run(32'h1, 11'd8, 32'ha5, r);
        check("cfg byte", {24'h0, cfg_byte}, 32'ha5);
        check("cfg pulses", n_vld, 32'h1);
        check("cfg busy", {31'h0, cfg_busy}, 32'h1);
        run(32'h3, 11'd0, {22'h0, `BST_I_EXTEST}, r);
        check("pins in cfg", {31'h0, pin_out === core_out}, 32'h1);
        run(32'h1, 11'd2, 32'h1, r);
        check("cfg bypass", {30'h0, r[31:30]}, 32'h2);
        run(32'h3, 11'd0, {22'h0, `BST_I_CFGEND}, r);
        check("cfg ended", {31'h0, cfg_busy}, 32'h0);
    endtask : t_cfg

    // ---------------------------------------------------------------
    // sequence and verdict
    // ---------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        // late update so the waiting resets see a falling edge
        rstn <= 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        usr_bits = 7'h5b;
        pin_in = {16'ha1b2, {29{16'h5c3d}}};
        core_out = {15{32'h0f0f_c3c3}};
        n_errors = 0;
        checks_done = 0;
        n_vld = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs;
        t_ident;
        t_user;
        t_bypass;
        t_pins;
        t_cfg;
        t_ident;
        stop_test;
    end
    initial begin
        #(25 * 60000);
        n_errors++;
        $display("watchdog ran out");
        stop_test;
    end
endmodule : bst_tap_bench
